//--- dv/ftr_ctrl_monitor.sv
// Purpose: port checker for ftr_ctrl
// Assumes: bench keeps segment lengths short
// Notes: trigger b and c share trigger one
`timescale 1ns/1ps
`default_nettype none
`include "ftr_params.svh"
module ftr_ctrl_monitor #(parameter int NSEG = 8) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sweep_enable,
  input wire logic [`FTR_DEV_W-1:0] shift_deviation_value,
  input wire logic [1:0] shift_trigger_select,
  input wire logic [4:0] modulation_pin_function,
  input wire logic [3:0] trigger_a_source,
  input wire logic [`FTR_NUM_W-1:0] carrier_numerator,
  input wire logic modulation_input_pin,
  input wire logic trigger_input_one,
  input wire logic [NSEG*2-1:0] segment_advance_event,
  input wire logic [`FTR_NUM_W-1:0] frac_numerator,
  input wire logic shift_active,
  input wire logic [`FTR_SEG_W-1:0] segment_index,
  input wire logic [2:0] pin_is_input
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // advance code of the running segment
  wire logic [1:0] adv = segment_advance_event[2*segment_index +: 2];
  wire logic fsk = sweep_enable && shift_trigger_select == 2'h1 &&
    trigger_a_source == 4'h3 && modulation_pin_function == 5'h07;
  sequence s_quiet;
    (fsk && !$rose(modulation_input_pin)) [*4];
  endsequence
  sequence s_wait;
    (sweep_enable && adv != 2'h0 && $stable(segment_index)) [*3];
  endsequence
  a_pin_input_map: assert property ($past(rst_b) |->
    pin_is_input[0] == ($past(modulation_pin_function) == 5'h07))
    else $error("pin function map");
  a_shift_on_edge: assert property (fsk &&
    $rose(modulation_input_pin) |-> ##[1:3] $changed(shift_active))
    else $error("no shift on edge");
  a_shift_quiet: assert property (s_quiet |=> $stable(shift_active))
    else $error("shift without edge");
  a_shift_off: assert property (!sweep_enable [*2] |=> !shift_active)
    else $error("shift while disabled");
  a_dev_step: assert property ($rose(shift_active) &&
    $stable(carrier_numerator) |-> frac_numerator ==
    $past(frac_numerator) + {11'h0, shift_deviation_value})
    else $error("deviation step");
  a_wait_holds: assert property ((sweep_enable && adv != 2'h0 &&
    !$rose(trigger_input_one)) [*4] |=> $stable(segment_index))
    else $error("left wait early");
  a_trig_starts: assert property (s_wait ##0
    $rose(trigger_input_one) |-> ##[1:4] $changed(segment_index))
    else $error("trigger ignored");
  a_len_ends: assert property ($changed(segment_index) &&
    adv == 2'h0 && sweep_enable |->
    ##[1:300] ($changed(segment_index) || !sweep_enable))
    else $error("segment never ends");
endmodule
bind ftr_ctrl ftr_ctrl_monitor #(.NSEG(NSEG)) u_mon (.core_clk, .rst_b,
  .sweep_enable, .shift_deviation_value, .shift_trigger_select,
  .modulation_pin_function, .trigger_a_source, .carrier_numerator,
  .modulation_input_pin, .trigger_input_one, .segment_advance_event,
  .frac_numerator, .shift_active, .segment_index, .pin_is_input);
`default_nettype wire

//--- dv/ftr_trig_src.sv
// Purpose: trigger source model for the pins
// Assumes: one pulse per request
// Notes: long hold acts as a slow source
`timescale 1ns/1ps
`default_nettype none
module ftr_trig_src (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [3:0] hold,
  output logic [2:0] pins
);
  logic [3:0] left = 4'h0;
  logic [1:0] cur = 2'h0;
  // pulse the chosen pin, then release it low
  always_ff @(posedge core_clk) begin
    if (left != 4'h0)
      left <= left - 4'h1;
    else if (go) begin
      left <= hold;
      cur <= sel;
    end
  end
  assign pins = (left != 4'h0) ? (3'h1 << cur) : 3'h0;
endmodule
`default_nettype wire

//--- dv/tb_fsk_trigger_ramp_control.sv
// Purpose: bench for shift keying and trigger ramps
// Assumes: increments zero during shift tests
// Notes: frac_numerator changes are scored against a queue
`timescale 1ns/1ps
`default_nettype none
`include "ftr_params.svh"
module tb_fsk_trigger_ramp_control;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sweep_enable = 1'b0;
  logic [`FTR_DEV_W-1:0] shift_deviation_value = '0;
  logic [1:0] shift_trigger_select = 2'h1;
  logic [4:0] modulation_pin_function = 5'h07;
  logic [4:0] trigger_one_pin_function = 5'h07;
  logic [4:0] trigger_two_pin_function = 5'h07;
  logic [3:0] trigger_a_source = 4'h3;
  logic [3:0] trigger_b_source = 4'h0;
  logic [3:0] trigger_c_source = 4'h0;
  logic [32:0] carrier_numerator = '0;
  logic [239:0] segment_increment = '0;
  logic [127:0] segment_length = '0;
  logic [15:0] segment_advance_event = '0;
  logic [7:0] segment_accumulator_clear = '0;
  logic [23:0] segment_successor = '0;
  logic [32:0] frac_numerator;
  logic shift_active;
  logic [2:0] segment_index;
  logic [2:0] pin_is_input;
  logic [2:0] pins;
  logic go = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [3:0] hold = 4'h1;
  logic [32:0] q[$];
  logic [32:0] last = '0;
  int seed = 68138;
  int err_count = 0;
  int compares = 0;
  always #2 core_clk = ~core_clk;
  ftr_trig_src u_src (.core_clk, .go, .sel, .hold, .pins);
  ftr_ctrl u_dut (.core_clk, .rst_b, .sweep_enable, .shift_deviation_value,
    .shift_trigger_select, .modulation_pin_function,
    .trigger_one_pin_function, .trigger_two_pin_function, .trigger_a_source,
    .trigger_b_source, .trigger_c_source, .carrier_numerator,
    .modulation_input_pin(pins[0]), .trigger_input_one(pins[1]),
    .trigger_input_two(pins[2]), .segment_increment, .segment_length,
    .segment_advance_event, .segment_accumulator_clear, .segment_successor,
    .frac_numerator, .shift_active, .segment_index, .pin_is_input);
  task automatic cmp(input string n, input logic [32:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // every frac_numerator change must match the oldest note
  always @(negedge core_clk) begin
    if (rst_b && frac_numerator !== last) begin
      cmp("frac_numerator", q.size() ? q.pop_front() : last, frac_numerator);
      last = frac_numerator;
    end
  end
  // one pin pulse with a random hold, then a quiet gap
  task pulse(input logic [1:0] s);
    @(posedge core_clk);
    #1 go = 1'b1;
    sel = s;
    hold = 4'h1 + 4'($unsigned($random(seed)) % 4);
    @(posedge core_clk);
    #1 go = 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  task drain;
    for (int i = 0; i < 200 && q.size() != 0; i++) @(posedge core_clk);
    if (q.size() != 0) begin
      err_count++;
      finish_test;
    end
  endtask
  initial begin
    logic [32:0] inc;
    int len;
    shift_deviation_value = 22'($random(seed));
    carrier_numerator = {1'b0, $random(seed)};
    segment_length[31:0] = 32'h0003_0002;
    segment_successor = 24'h1;
    q.push_back(carrier_numerator);
    repeat (4) @(posedge core_clk);
    #1 rst_b = 1'b1;
    sweep_enable = 1'b1;
    for (int i = 1; i <= 5; i++) begin
      q.push_back(carrier_numerator + (i % 2 ? 33'(shift_deviation_value) : 33'h0));
      pulse(2'h0);
      #1 cmp("shift_active", 33'(i % 2), 33'(shift_active));
    end
    #1 sweep_enable = 1'b0;
    q.push_back(carrier_numerator);
    drain;
    cmp("shift_active", 33'h0, 33'(shift_active));
    cmp("pin_is_input", 33'h7, 33'(pin_is_input));
    $display("test shift keying done");
    #1 modulation_pin_function = 5'h00;
    sweep_enable = 1'b1;
    pulse(2'h0);
    #1 cmp("pin_is_input", 33'h6, 33'(pin_is_input));
    cmp("shift_active", 33'h0, 33'(shift_active));
    sweep_enable = 1'b0;
    $display("test pin refusal done");
    shift_trigger_select = 2'h0;
    modulation_pin_function = 5'h07;
    carrier_numerator = {1'b0, $random(seed)};
    q.push_back(carrier_numerator);
    len = 1 + ($unsigned($random(seed)) % 5);
    inc = 33'($unsigned($random(seed)) % 200) + 33'h1;
    segment_increment[59:30] = inc[29:0];
    segment_length[31:16] = 16'(len);
    segment_accumulator_clear[0] = 1'b1;
    sweep_enable = 1'b1;
    for (int k = 1; k <= 3; k++) begin
      segment_advance_event[1:0] = 2'(k);
      {trigger_c_source, trigger_b_source, trigger_a_source} = 12'h1 << (4 * (k - 1));
      repeat (10) @(posedge core_clk);
      #1 cmp("segment_index", 33'h0, 33'(segment_index));
      for (int i = 1; i <= len; i++) q.push_back(carrier_numerator + 33'(i) * inc);
      q.push_back(carrier_numerator);
      pulse(2'h1);
      drain;
      #1 $display("test ramp round %0d done", k);
    end
    finish_test;
  end
endmodule
`default_nettype wire

//--- rtl/ftr_ctrl.sv
// Functional notes
// (RL1) deviation equals fpd times value over 2^24
// (RL2) trigger arrives on modulation or trigger pins
// (RL3) pin function 7 makes pin an input
// (RL4) shift select 1 uses trigger A
// (RL5) source 3: modulation rising edge adds deviation
// (RL6) shift keying only while sweep enabled
// (RL7) pfd rate is fin/R, vco fpd*N
// (RL8) a segment may wait for trigger
// (RL9) trigger starts next segment sweeping its length
// (RL10) advance event: 0 length, 1-3 triggers A-C
// (RL11) accumulator-clear bit clears ramp at segment start
// (RL12) timeout moves to successor segment index
//
// Purpose: trigger driven shift keying and ramp segment sequencer
// Assumes: core_clk is the phase detector clock, pins synchronous
// Notes: outputs the carrier numerator plus the ramp and deviation offsets
`timescale 1ns/1ps
`default_nettype none
`include "ftr_params.svh"
module ftr_ctrl #(
  parameter int NSEG = `FTR_NSEG,
  parameter int LEN_W = `FTR_LEN_W
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic sweep_enable,
  input wire logic [`FTR_DEV_W-1:0] shift_deviation_value,
  input wire logic [1:0] shift_trigger_select,
  input wire logic [4:0] modulation_pin_function,
  input wire logic [4:0] trigger_one_pin_function,
  input wire logic [4:0] trigger_two_pin_function,
  input wire logic [3:0] trigger_a_source,
  input wire logic [3:0] trigger_b_source,
  input wire logic [3:0] trigger_c_source,
  input wire logic [`FTR_NUM_W-1:0] carrier_numerator,
  input wire logic modulation_input_pin,
  input wire logic trigger_input_one,
  input wire logic trigger_input_two,
  input wire logic [NSEG*`FTR_INC_W-1:0] segment_increment,
  input wire logic [NSEG*LEN_W-1:0] segment_length,
  input wire logic [NSEG*2-1:0] segment_advance_event,
  input wire logic [NSEG-1:0] segment_accumulator_clear,
  input wire logic [NSEG*`FTR_SEG_W-1:0] segment_successor,
  output logic [`FTR_NUM_W-1:0] frac_numerator,
  output logic shift_active,
  output logic [`FTR_SEG_W-1:0] segment_index,
  output logic [2:0] pin_is_input
);
  import ftr_pkg::*;
  // operation overview for the next maintainer:
  // - core_clk is the phase detector clock, so one ramp tick is one edge
  // - the carrier numerator is formed outside and arrives as a level
  // - frac_numerator = carrier + ramp accumulator + optional deviation
  // - the sum wraps modulo 2^33, as the divider numerator does
  // - the deviation counts are numerator units over a 2^24 denominator
  // - so the frequency step is fpd times the value over 2^24
  // pin handling:
  // - each pin is sampled once per edge; no synchroniser here
  // - callers must deliver pins already in the core_clk domain
  // - a pin whose function code is not input yields no edge at all
  // - the edge history runs even for ignored pins, so enabling a pin
  //   while it sits high gives no false rising edge next cycle? no:
  //   the history is current, so only a genuine low-to-high counts
  // trigger decode:
  // - three trigger slots share one decoder instance
  // - each slot selects one of six pin edges, other codes give none
  // shift keying:
  // - every selected edge toggles the deviation on or off
  // - a square wave on the pin therefore gives two-tone keying
  // - dropping sweep_enable clears the shift state at once
  // ramp sequencer:
  // - idle until sweep_enable, then load segment zero
  // - load copies the length and optionally clears the accumulator
  // - run counts the length down, adding the increment each tick
  // - length l gives exactly l increments before the advance
  // - trigger-advance segments hold their value until the event
  // - a trigger-advance segment does not count its length
  // - on advance the successor index is loaded next cycle
  // hazards and limits:
  // - a trigger that arrives during load is lost; load lasts one tick
  // - accumulator overflow wraps silently, no limit comparators here
  // - increments are signed, so down ramps use negative values
  // - outputs lag internal state by one register stage
  ftr_trig_if tif();
  ftr_state_t state, next_state;
  logic [2:0] pin_q;
  logic [`FTR_SEG_W-1:0] seg, next_seg;
  logic [LEN_W-1:0] len_cnt;
  ftr_num_t ramp_acc;
  logic shift_on;
  // pins used as triggers must be configured as inputs
  wire [2:0] pin_in = {
    trigger_two_pin_function == `FTR_PIN_FN_INPUT,
    trigger_one_pin_function == `FTR_PIN_FN_INPUT,
    modulation_pin_function == `FTR_PIN_FN_INPUT}; // [RL3]
  wire [2:0] pin_now = {trigger_input_two, trigger_input_one,
    modulation_input_pin}; // [RL2]
  // edges only count on pins that are inputs
  assign tif.rise = pin_in & pin_now & ~pin_q;
  assign tif.fall = pin_in & ~pin_now & pin_q;
  assign tif.src_a = trigger_a_source; // [RL5]
  assign tif.src_b = trigger_b_source;
  assign tif.src_c = trigger_c_source;
  ftr_trig_dec u_dec (
    .t(tif.dec)
  );
  wire [2:0] trig = tif.event_abc;
  // shift keying toggles on the selected trigger
  wire shift_trig = (shift_trigger_select == `FTR_SHIFT_TRIG_A) ? trig[0]
    : (shift_trigger_select == 2'h2) ? trig[1]
    : (shift_trigger_select == 2'h3) ? trig[2] : 1'b0; // [RL4]
  // current segment fields
  wire [1:0] adv = segment_advance_event[seg*2 +: 2];
  wire [LEN_W-1:0] seg_len = segment_length[seg*LEN_W +: LEN_W];
  wire [`FTR_INC_W-1:0] seg_inc =
    segment_increment[seg*`FTR_INC_W +: `FTR_INC_W];
  wire [`FTR_SEG_W-1:0] seg_next =
    segment_successor[seg*`FTR_SEG_W +: `FTR_SEG_W];
  wire len_done = (len_cnt == {LEN_W{1'b0}});
  // trigger-advance segments hold at their value while waiting
  wire adv_hit = (adv == `FTR_ADV_LEN) ? len_done
    : (adv == `FTR_ADV_TRIG_A) ? trig[0]
    : (adv == `FTR_ADV_TRIG_B) ? trig[1] : trig[2]; // [RL8] [RL10]
  wire counting = (adv == `FTR_ADV_LEN) && !len_done;
  wire clr_now = segment_accumulator_clear[seg]; // [RL11]
  // deviation as numerator counts; fpd*dev/2^24 in frequency
  wire [`FTR_NUM_W-1:0] dev_term = shift_on
    ? {{(`FTR_NUM_W-`FTR_DEV_W){1'b0}}, shift_deviation_value}
    : {`FTR_NUM_W{1'b0}}; // [RL1]
  wire [`FTR_NUM_W-1:0] inc_ext =
    {{(`FTR_NUM_W-`FTR_INC_W){seg_inc[`FTR_INC_W-1]}}, seg_inc};
  // sequencer next state
  always_comb begin
    next_state = state;
    next_seg = seg;
    case (state)
      FTR_IDLE: begin
        next_seg = {`FTR_SEG_W{1'b0}};
        if (sweep_enable) begin
          next_state = FTR_LOAD;
        end
      end
      FTR_LOAD: begin
        next_state = FTR_RUN;
      end
      FTR_RUN: begin
        if (adv_hit) begin
          next_seg = seg_next; // [RL9] [RL12]
          next_state = FTR_LOAD;
        end
      end
      default: begin
        next_state = FTR_IDLE;
      end
    endcase
    if (!sweep_enable) begin
      next_state = FTR_IDLE;
    end
  end
  // state and pin history
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= FTR_IDLE;
      seg <= {`FTR_SEG_W{1'b0}};
      pin_q <= 3'h0;
    end else begin
      state <= next_state;
      seg <= next_seg;
      pin_q <= pin_now;
    end
  end
  // length counter reloads at each segment start
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      len_cnt <= {LEN_W{1'b0}};
    end else if (state == FTR_LOAD) begin
      len_cnt <= seg_len; // [RL9]
    end else if (state == FTR_RUN && counting) begin
      len_cnt <= len_cnt - 1'b1; // [RL10]
    end
  end
  // ramp accumulator, optional clear at segment start
  always_ff @(posedge core_clk) begin
    if (!rst_b || state == FTR_IDLE) begin
      ramp_acc <= {`FTR_NUM_W{1'b0}};
    end else if (state == FTR_LOAD && clr_now) begin
      ramp_acc <= {`FTR_NUM_W{1'b0}}; // [RL11]
    end else if (state == FTR_RUN && counting) begin
      ramp_acc <= ramp_acc + inc_ext; // [RL9]
    end
  end
  // shift keying toggles per edge, only while sweep enabled
  always_ff @(posedge core_clk) begin
    if (!rst_b || !sweep_enable) begin
      shift_on <= 1'b0; // [RL6]
    end else if (shift_trig) begin
      shift_on <= !shift_on; // [RL5]
    end
  end
  // registered outputs; numerator drives the feedback divider [RL7]
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      frac_numerator <= {`FTR_NUM_W{1'b0}};
      shift_active <= 1'b0;
      segment_index <= {`FTR_SEG_W{1'b0}};
      pin_is_input <= 3'h0;
    end else begin
      frac_numerator <= carrier_numerator + ramp_acc + dev_term; // [RL1]
      shift_active <= shift_on;
      segment_index <= seg;
      pin_is_input <= pin_in; // [RL3]
    end
  end
endmodule
`default_nettype wire

//--- rtl/ftr_params.svh
// Purpose: constants for the shift keying and ramp segment controller
// Assumes: fields are plain ports, no register bus
// Notes: widths follow the synthesizer numerator arithmetic
`ifndef FTR_PARAMS_SVH
`define FTR_PARAMS_SVH
`define FTR_FRAC_BITS 24
`define FTR_NUM_W 33
`define FTR_DEV_W 22
`define FTR_INC_W 30
`define FTR_LEN_W 16
`define FTR_SEG_W 3
`define FTR_NSEG 8
`define FTR_PIN_FN_INPUT 5'h07
`define FTR_SHIFT_TRIG_A 2'h1
`define FTR_TRIG_SRC_MOD_RISE 4'h3
`define FTR_TRIG_SRC_T1_RISE 4'h1
`define FTR_TRIG_SRC_T2_RISE 4'h2
`define FTR_TRIG_SRC_MOD_FALL 4'h4
`define FTR_TRIG_SRC_T1_FALL 4'h5
`define FTR_TRIG_SRC_T2_FALL 4'h6
`define FTR_ADV_LEN 2'h0
`define FTR_ADV_TRIG_A 2'h1
`define FTR_ADV_TRIG_B 2'h2
`define FTR_ADV_TRIG_C 2'h3
`endif

//--- rtl/ftr_pkg.sv
// Purpose: types for the shift keying and ramp segment controller
// Assumes: included constants header
// Notes: one-hot sequencer states
`include "ftr_params.svh"
package ftr_pkg;
  typedef enum logic [2:0] {
    FTR_IDLE = 3'h1,
    FTR_LOAD = 3'h2,
    FTR_RUN = 3'h4
  } ftr_state_t;
  typedef logic [`FTR_NUM_W-1:0] ftr_num_t;
endpackage

//--- rtl/ftr_trig_dec.sv
// Purpose: maps a trigger source code to a pin edge event
// Assumes: edges already detected, pins sampled synchronously
// Notes: one decoder serves triggers a, b and c
`timescale 1ns/1ps
`default_nettype none
`include "ftr_params.svh"
module ftr_trig_dec (
  ftr_trig_if.dec t
);
  import ftr_pkg::*;
  function automatic logic pick(input logic [3:0] src, input logic [2:0] r,
                                input logic [2:0] f);
    case (src)
      `FTR_TRIG_SRC_T1_RISE: pick = r[1];
      `FTR_TRIG_SRC_T2_RISE: pick = r[2];
      `FTR_TRIG_SRC_MOD_RISE: pick = r[0];
      `FTR_TRIG_SRC_MOD_FALL: pick = f[0];
      `FTR_TRIG_SRC_T1_FALL: pick = f[1];
      `FTR_TRIG_SRC_T2_FALL: pick = f[2];
      default: pick = 1'b0;
    endcase
  endfunction
  // combinational selection, registered by the caller
  assign t.event_abc[0] = pick(t.src_a, t.rise, t.fall);
  assign t.event_abc[1] = pick(t.src_b, t.rise, t.fall);
  assign t.event_abc[2] = pick(t.src_c, t.rise, t.fall);
endmodule
`default_nettype wire

//--- rtl/ftr_trig_if.sv
// Purpose: carries pin edge events to the trigger decoder
// Assumes: single clock domain
// Notes: events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface ftr_trig_if;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [3:0] src_a;
  logic [3:0] src_b;
  logic [3:0] src_c;
  logic [2:0] event_abc;
  modport pins(output rise, output fall, input event_abc,
    output src_a, output src_b, output src_c);
  modport dec(input rise, input fall, input src_a, input src_b,
    input src_c, output event_abc);
endinterface
`default_nettype wire
